// file: core/spi_manual_params.svh
// Purpose: offsets, field positions, reset values and timing counts of the manual transfer block
// Assumes: 32-bit AHB-Lite register words, byte addresses in the low eight address bits
// Notes: included by its bare name
`ifndef SPI_MANUAL_PARAMS_SVH
`define SPI_MANUAL_PARAMS_SVH

// register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_PHASE_ENABLE 8'h04
`define OFS_DOUBLE_RATE 8'h08
`define OFS_DUMMY_SETUP 8'h0c
`define OFS_COMMAND 8'h10
`define OFS_ADDRESS 8'h14
`define OFS_OPTION 8'h18
`define OFS_READ0 8'h1c
`define OFS_READ1 8'h20
`define OFS_WRITE0 8'h24
`define OFS_WRITE1 8'h28

// control register bits
`define CTRL_START 0
`define CTRL_READ 1
`define CTRL_WRITE 2

// phase enable register fields
`define PEN_DATA_LO 0
`define PEN_OPT_LO 4
`define PEN_ADDR_LO 8
`define PEN_OCMD 12
`define PEN_CMD 14
`define PEN_DUMMY 15
`define PEN_DATAW_LO 16
`define PEN_OPTW_LO 20
`define PEN_ADDRW_LO 24
`define PEN_OCMDW_LO 28
`define PEN_CMDW_LO 30

// double rate register bits
`define DDR_DATA 0
`define DDR_OPT 4
`define DDR_ADDR 8

// dummy setup fields
`define DMY_COUNT_LO 0
`define DMY_WIDTH_LO 16

// command register fields
`define CMD_OPT_LO 0
`define CMD_CODE_LO 16

// width code for four data lines; every other code means one line
`define WIDTH_FOUR 2'h2

`define RESET_WORD 32'h00000000
`define SCK_HALF_DEFAULT 4

`endif

// file: core/spi_manual_pkg.sv
// Purpose: types of the manual transfer block
// Assumes: constants live in spi_manual_params.svh
// Notes: used with package-qualified names only
package spi_manual_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_FINISH = 2'b10
    } state_type;

    typedef enum logic [2:0] {
        PH_CMD = 3'b000,
        PH_OCMD = 3'b001,
        PH_ADDR = 3'b010,
        PH_OPT = 3'b011,
        PH_DUMMY = 3'b100,
        PH_DATA = 3'b101,
        PH_END = 3'b110
    } phase_type;

    typedef struct packed {
        logic [63:0] src;
        logic [6:0] bits;
        logic wide;
        logic ddr;
        logic drive;
    } setup_type;

    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [31:0] phase_en;
        logic [31:0] ddr_reg;
        logic [31:0] dummy_reg;
        logic [31:0] cmd_reg;
        logic [31:0] addr_reg;
        logic [31:0] opt_reg;
        logic [31:0] rd0;
        logic [31:0] rd1;
        logic [31:0] wr0;
        logic [31:0] wr1;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
        state_type state;
        phase_type phase;
        logic [63:0] shift;
        logic [6:0] bits_left;
        logic wide;
        logic ddr;
        logic drive;
        logic [63:0] rd_shift;
        logic [6:0] rd_count;
        logic [7:0] div_cnt;
        logic sck;
        logic cs_n;
        logic [3:0] io_out;
        logic [3:0] io_oe_n;
        logic [3:0] sync1;
        logic [3:0] sync2;
    } core_type;

endpackage

// file: core/spi_manual_xfer.sv
// Purpose: software-driven serial flash transfer with AHB-Lite register access
// Assumes: one flash on a four-line bus, clock mode 0, i_mclk 125 MHz
// Notes: every bus transfer takes one wait state; start is ignored while busy
// Notes on behaviour
// - read data is captured only while the read enable bit is set
// - write data is driven only if the write enable bit is already set when the data phase is loaded
// - dummy phase happens only when dummy enable is set
// - address phase uses single or double rate per its select bit
// - option data phase uses single or double rate per its select bit
// - data phase uses single or double rate per its select bit
// - dummy phase runs on one or four lines per its width field
// - one to eight dummy cycles chosen by a three-bit count
// - command phase sends the eight-bit command byte
// - optional command phase sends the second eight-bit command byte
// - address comes from the 32-bit address register
// - option phase draws on four option bytes, three down to zero
// - received data readable in two 32-bit read words
// - sent data taken from two 32-bit write words
// - width code zero means one line, code two four lines
// - dummy count holds cycles minus one
// - option enable selects bytes from byte three downward
`timescale 1ns/1ns
`include "spi_manual_params.svh"

module spi_manual_xfer #(
    parameter int SCK_HALF_CYCLES = `SCK_HALF_DEFAULT
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // flash pins
    output logic o_sck,
    output logic o_cs_n,
    input wire logic [3:0] i_io,
    output logic [3:0] o_io,
    output logic [3:0] o_io_oe_n
);

    // the divider counter is eight bits
    if (SCK_HALF_CYCLES < 1 || SCK_HALF_CYCLES > 256) begin : bad_half
        $error("SCK_HALF_CYCLES must lie in 1 to 256");
    end

    // last count of a half period
    localparam logic [7:0] HALF_LAST = 8'(SCK_HALF_CYCLES - 1);

    spi_manual_pkg::core_type cur;
    spi_manual_pkg::core_type next_cur;

    // number of leading ones from bit three down
    function automatic logic [2:0] lead_ones(input logic [3:0] d);
        logic [2:0] n;
        n = 3'd0;
        if (d[3]) begin
            n = 3'd1;
            if (d[2]) begin
                n = 3'd2;
                if (d[1]) begin
                    n = d[0] ? 3'd4 : 3'd3;
                end
            end
        end

        return n;
    endfunction

    // count of set bits
    function automatic logic [2:0] ones(input logic [3:0] d);
        return {2'b00, d[0]} + {2'b00, d[1]} + {2'b00, d[2]} + {2'b00, d[3]};
    endfunction

    // enable bit of each phase
    function automatic logic phase_on(input logic [2:0] p, input spi_manual_pkg::core_type c);
        logic r;
        r = 1'b0;
        case (p)
            3'd0: r = c.phase_en[`PEN_CMD];
            3'd1: r = c.phase_en[`PEN_OCMD];
            3'd2: r = |c.phase_en[`PEN_ADDR_LO +: 4];
            3'd3: r = c.phase_en[`PEN_OPT_LO + 3];
            3'd4: r = c.phase_en[`PEN_DUMMY];
            3'd5: r = c.phase_en[`PEN_DATA_LO + 3];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // first enabled phase at or after the given one
    function automatic spi_manual_pkg::phase_type first_on(input logic [2:0] from,
                                                          input spi_manual_pkg::core_type c);
        spi_manual_pkg::phase_type r;
        r = spi_manual_pkg::PH_END;
        for (int k = 5; k >= 0; k--) begin
            if (3'(k) >= from && phase_on(3'(k), c)) begin
                r = spi_manual_pkg::phase_type'(3'(k));
            end
        end
        return r;
    endfunction

    // source, bit count, width and rate of a phase
    function automatic spi_manual_pkg::setup_type setup(input spi_manual_pkg::phase_type p,
                                                       input spi_manual_pkg::core_type c);
        spi_manual_pkg::setup_type s;
        logic [2:0] n;
        logic [3:0] cyc;
        s = '0;
        n = 3'd0;
        cyc = 4'd0;
        case (p)
            spi_manual_pkg::PH_CMD: begin
                s.src = {c.cmd_reg[`CMD_CODE_LO +: 8], 56'h0};
                s.bits = 7'd8;
                s.wide = c.phase_en[`PEN_CMDW_LO +: 2] == `WIDTH_FOUR;
                s.drive = 1'b1;
            end

            spi_manual_pkg::PH_OCMD: begin
                s.src = {c.cmd_reg[`CMD_OPT_LO +: 8], 56'h0};
                s.bits = 7'd8;
                s.wide = c.phase_en[`PEN_OCMDW_LO +: 2] == `WIDTH_FOUR;
                s.drive = 1'b1;
            end
            // low address bytes of the register
            spi_manual_pkg::PH_ADDR: begin
                n = ones(c.phase_en[`PEN_ADDR_LO +: 4]);
                s.src = {c.addr_reg << {3'd4 - n, 3'b000}, 32'h0};
                s.bits = {1'b0, n, 3'b000};
                s.wide = c.phase_en[`PEN_ADDRW_LO +: 2] == `WIDTH_FOUR;
                s.ddr = c.ddr_reg[`DDR_ADDR];
                s.drive = 1'b1;
            end

            spi_manual_pkg::PH_OPT: begin
                n = lead_ones(c.phase_en[`PEN_OPT_LO +: 4]);
                s.src = {c.opt_reg, 32'h0};
                s.bits = {1'b0, n, 3'b000};
                s.wide = c.phase_en[`PEN_OPTW_LO +: 2] == `WIDTH_FOUR;
                s.ddr = c.ddr_reg[`DDR_OPT];
                s.drive = 1'b1;
            end
            // zeros on the selected lines
            spi_manual_pkg::PH_DUMMY: begin
                cyc = {1'b0, c.dummy_reg[`DMY_COUNT_LO +: 3]} + 4'd1;
                s.wide = c.dummy_reg[`DMY_WIDTH_LO +: 2] == `WIDTH_FOUR;
                s.bits = s.wide ? {1'b0, cyc, 2'b00} : {3'b000, cyc};
                s.drive = 1'b1;
            end
            // lines released unless write enable
            spi_manual_pkg::PH_DATA: begin
                n = lead_ones(c.phase_en[`PEN_DATA_LO +: 4]);
                s.ddr = c.ddr_reg[`DDR_DATA];
                s.bits = s.ddr ? {n, 3'b000, 1'b0} : {1'b0, n, 3'b000};
                s.src = {c.wr0, c.wr1};
                s.wide = c.phase_en[`PEN_DATAW_LO +: 2] == `WIDTH_FOUR;
                s.drive = c.wr_en;
            end
            default: s = '0;
        endcase

        return s;
    endfunction

    // unmapped offsets read zero
    function automatic logic [31:0] read_reg(input logic [7:0] a,
                                             input spi_manual_pkg::core_type c);
        logic [31:0] r;
        r = `RESET_WORD;
        case (a)
            `OFS_CONTROL: r = {29'h0, c.wr_en, c.rd_en, c.state != spi_manual_pkg::ST_IDLE};
            `OFS_PHASE_ENABLE: r = c.phase_en;
            `OFS_DOUBLE_RATE: r = c.ddr_reg;
            `OFS_DUMMY_SETUP: r = c.dummy_reg;
            `OFS_COMMAND: r = c.cmd_reg;
            `OFS_ADDRESS: r = c.addr_reg;
            `OFS_OPTION: r = c.opt_reg;
            `OFS_READ0: r = c.rd0;
            `OFS_READ1: r = c.rd1;
            `OFS_WRITE0: r = c.wr0;
            `OFS_WRITE1: r = c.wr1;
            default: r = `RESET_WORD;
        endcase
        return r;
    endfunction

    // all next-state logic
    always_comb begin
        spi_manual_pkg::setup_type su;
        spi_manual_pkg::phase_type nxt;
        logic start;
        logic tick;
        logic shift_ev;
        logic sample_ev;
        logic [6:0] step;
        logic [63:0] aligned;
        su = '0;
        nxt = spi_manual_pkg::PH_END;
        start = 1'b0;
        tick = 1'b0;
        shift_ev = 1'b0;
        sample_ev = 1'b0;
        step = cur.wide ? 7'd4 : 7'd1;
        aligned = 64'h0;
        next_cur = cur;

        // pins from outside pass two flip-flops
        next_cur.sync1 = i_io;
        next_cur.sync2 = cur.sync1;

        // bus: data phase one cycle after the address phase, with one wait state
        next_cur.hreadyout = 1'b1;
        next_cur.ap_valid = 1'b0;
        if (cur.ap_valid) begin
            next_cur.hrdata = read_reg(cur.ap_addr, cur);
            if (cur.ap_write) begin
                case (cur.ap_addr)
                    `OFS_CONTROL: begin
                        next_cur.rd_en = i_hwdata[`CTRL_READ];
                        next_cur.wr_en = i_hwdata[`CTRL_WRITE];
                        start = i_hwdata[`CTRL_START];
                    end
                    `OFS_PHASE_ENABLE: next_cur.phase_en = i_hwdata;
                    `OFS_DOUBLE_RATE: next_cur.ddr_reg = i_hwdata;
                    `OFS_DUMMY_SETUP: next_cur.dummy_reg = i_hwdata;
                    `OFS_COMMAND: next_cur.cmd_reg = i_hwdata;
                    `OFS_ADDRESS: next_cur.addr_reg = i_hwdata;
                    `OFS_OPTION: next_cur.opt_reg = i_hwdata;
                    `OFS_WRITE0: next_cur.wr0 = i_hwdata;
                    `OFS_WRITE1: next_cur.wr1 = i_hwdata;
                    // read words are not writable
                    default: next_cur.ap_write = 1'b0;
                endcase
            end
        end

        if (i_hsel && i_hready && i_htrans[1]) begin
            next_cur.ap_valid = 1'b1;
            next_cur.ap_write = i_hwrite;
            next_cur.ap_addr = i_haddr[7:0];
            next_cur.hreadyout = 1'b0;
        end

        // serial clock half-period divider
        if (cur.state != spi_manual_pkg::ST_IDLE) begin
            if (cur.div_cnt == HALF_LAST) begin
                tick = 1'b1;
                next_cur.div_cnt = 8'h00;
            end else begin
                next_cur.div_cnt = cur.div_cnt + 8'h01;
            end
        end

        // start acts only from idle
        case (cur.state)
            spi_manual_pkg::ST_IDLE: begin
                if (start) begin
                    nxt = first_on(3'd0, cur);
                    su = setup(nxt, cur);
                    next_cur.cs_n = 1'b0;
                    next_cur.div_cnt = 8'h00;
                    next_cur.rd_shift = 64'h0;
                    next_cur.rd_count = 7'd0;
                    next_cur.phase = nxt;
                    next_cur.shift = su.src;
                    next_cur.bits_left = su.bits;
                    next_cur.wide = su.wide;
                    next_cur.ddr = su.ddr;
                    next_cur.drive = su.drive;

                    next_cur.state = (nxt == spi_manual_pkg::PH_END) ?
                        spi_manual_pkg::ST_FINISH : spi_manual_pkg::ST_RUN;
                end
            end

            spi_manual_pkg::ST_RUN: begin
                if (tick) begin
                    next_cur.sck = ~cur.sck;
                    // single rate: sample on rise, shift on fall; double rate: both edges
                    sample_ev = cur.phase == spi_manual_pkg::PH_DATA && cur.rd_en &&
                        (!cur.sck || cur.ddr);
                    shift_ev = cur.sck || cur.ddr;
                end

                if (sample_ev) begin
                    next_cur.rd_shift = cur.wide ? {cur.rd_shift[59:0], cur.sync2} :
                        {cur.rd_shift[62:0], cur.sync2[1]};
                    next_cur.rd_count = cur.rd_count + step;
                end

                if (shift_ev) begin
                    // load the next enabled phase
                    if (cur.bits_left <= step) begin
                        nxt = first_on(cur.phase + 3'd1, cur);
                        su = setup(nxt, cur);
                        next_cur.phase = nxt;
                        next_cur.shift = su.src;
                        next_cur.bits_left = su.bits;
                        next_cur.wide = su.wide;
                        next_cur.ddr = su.ddr;
                        next_cur.drive = su.drive;
                        if (nxt == spi_manual_pkg::PH_END) begin
                            next_cur.state = spi_manual_pkg::ST_FINISH;
                        end
                    end else begin
                        next_cur.shift = cur.wide ? {cur.shift[59:0], 4'h0} :
                            {cur.shift[62:0], 1'b0};
                        next_cur.bits_left = cur.bits_left - step;
                    end
                end
            end

            spi_manual_pkg::ST_FINISH: begin
                if (tick) begin
                    // clock ends low, then select rises
                    if (cur.sck) begin
                        next_cur.sck = 1'b0;
                    end else begin
                        next_cur.cs_n = 1'b1;
                        next_cur.state = spi_manual_pkg::ST_IDLE;
                        if (cur.rd_en) begin
                            aligned = cur.rd_shift << (7'd64 - cur.rd_count);
                            next_cur.rd0 = aligned[63:32];
                            next_cur.rd1 = aligned[31:0];
                        end
                    end
                end
            end

            default: next_cur.state = spi_manual_pkg::ST_IDLE;
        endcase

        // pin drive follows the loaded phase
        next_cur.io_out = next_cur.wide ? next_cur.shift[63:60] : {3'b000, next_cur.shift[63]};

        if (next_cur.state == spi_manual_pkg::ST_RUN && next_cur.drive) begin
            next_cur.io_oe_n = next_cur.wide ? 4'h0 : 4'he;
        end else begin
            next_cur.io_oe_n = 4'hf;
        end
    end

    // state register
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            cur <= '0;
            // idle levels
            cur.cs_n <= 1'b1;
            cur.io_oe_n <= 4'hf;
            cur.hreadyout <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign o_hrdata = cur.hrdata;
    assign o_hreadyout = cur.hreadyout;
    assign o_hresp = cur.hresp;
    assign o_sck = cur.sck;
    assign o_cs_n = cur.cs_n;
    assign o_io = cur.io_out;
    assign o_io_oe_n = cur.io_oe_n;

endmodule

// file: tb/spi_manual_xfer_monitor.sv
// Purpose: port checker for the manual flash transfer block
// Assumes: bound to spi_manual_xfer, one clock domain
// Notes: sck half period measured by a run counter
`timescale 1ns/1ns
module spi_manual_xfer_monitor #(
    parameter int SCK_HALF_CYCLES = 4
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // bus
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    // flash
    input wire logic o_sck,
    input wire logic o_cs_n,
    input wire logic [3:0] i_io,
    input wire logic [3:0] o_io,
    input wire logic [3:0] o_io_oe_n
);
    logic sck_q;
    logic [8:0] run;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    // cycles the serial clock has held its present level
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            sck_q <= 1'b0;
            run <= 9'h000;
        end else begin
            sck_q <= o_sck;
            run <= (o_sck != sck_q) ? 9'h001 : run + 9'h001;
        end
    end
    property p_okay; o_hresp == 1'b0; endproperty
    a_okay: assert property (p_okay)
        else $error("bus response not okay");
    property p_wait;
        i_hsel && i_hready && i_htrans[1] |=> !o_hreadyout ##1 o_hreadyout;
    endproperty
    a_wait: assert property (p_wait)
        else $error("wait state missing");
    property p_ready_back; !o_hreadyout |=> o_hreadyout; endproperty
    a_ready_back: assert property (p_ready_back)
        else $error("wait state too long");
    property p_idle_sck; o_cs_n |-> !o_sck; endproperty
    a_idle_sck: assert property (p_idle_sck)
        else $error("clock active without select");
    property p_idle_oe; o_cs_n |-> o_io_oe_n == 4'hf; endproperty
    a_idle_oe: assert property (p_idle_oe)
        else $error("lines driven without select");
    property p_oe_code; o_io_oe_n inside {4'hf, 4'he, 4'h0}; endproperty
    a_oe_code: assert property (p_oe_code)
        else $error("bad line enable pattern");
    property p_half; $fell(o_sck) |-> run == SCK_HALF_CYCLES; endproperty
    a_half: assert property (p_half)
        else $error("clock high time wrong");
    property p_end_low; $rose(o_cs_n) |-> !$past(o_sck); endproperty
    a_end_low: assert property (p_end_low)
        else $error("select released with clock high");
    property p_start_low; $fell(o_cs_n) |-> !o_sck; endproperty
    a_start_low: assert property (p_start_low)
        else $error("frame opened with clock high");
    c_frame: cover property ($fell(o_cs_n));
    c_wide: cover property (!o_cs_n && o_io_oe_n == 4'h0);
    c_access: cover property (i_hsel && i_hready && i_htrans[1]);
endmodule
bind spi_manual_xfer spi_manual_xfer_monitor #(.SCK_HALF_CYCLES(SCK_HALF_CYCLES))
    i_spi_manual_xfer_monitor (.i_mclk(i_mclk), .i_reset(i_reset), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
    .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_sck(o_sck), .o_cs_n(o_cs_n),
    .i_io(i_io), .o_io(o_io), .o_io_oe_n(o_io_oe_n));

// file: tb/flash_model.sv
// Purpose: behavioural serial flash that records sent bits and returns a word
// Assumes: clock mode 0, read bits change after each falling clock edge
// Notes: lines not driven by the flash toggle every cycle
`timescale 1ns/1ns
module flash_model (
    // control from the bench
    input wire logic i_mclk,
    input wire logic i_clear,
    input wire logic [6:0] i_skip,
    input wire logic [63:0] i_resp,
    // flash pins
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic [3:0] i_io,
    input wire logic [3:0] i_io_oe_n,
    output logic [3:0] o_io,
    // observations
    output int o_rises,
    output int o_driven,
    output int o_wide,
    output logic [127:0] o_rx
);
    logic sck_q;
    int falls;
    logic [3:0] io_q;
    initial begin
        o_io = 4'h5;
        sck_q = 1'b0;
        falls = 0;
        io_q = 4'h0;
    end
    always @(negedge i_mclk) begin
        int k;
        if (i_clear) begin
            o_rises = 0;
            o_driven = 0;
            o_wide = 0;
        end
        if (!i_cs_n && i_sck && !sck_q) begin
            o_rises++;
            // the bit that stood before the edge
            o_rx = {o_rx[126:0], io_q[0]};
            if (!i_io_oe_n[0]) o_driven++;
            if (i_io_oe_n == 4'h0) o_wide++;
        end
        if (!i_cs_n && !i_sck && sck_q) falls++;
        if (i_cs_n) falls = 0;
        k = falls - int'(i_skip);
        // reply starts after the bench-given number of clock cycles
        if (!i_cs_n && k >= 0 && k < 64) o_io = {4{i_resp[63 - k]}};
        else o_io = ~o_io;
        sck_q = i_sck;
        io_q = i_io;
    end
endmodule

// file: tb/spi_manual_xfer_tb.sv
// Purpose: self-checking bench of the manual flash transfer block
// Assumes: flash_model on the pins, bus hready tied to hreadyout
// Notes: one task for each scenario
`timescale 1ns/1ns
`include "spi_manual_params.svh"
module spi_manual_xfer_tb;
    localparam int HALF = 4;
    logic i_mclk, i_reset, hsel, hwrite, clr, hreadyout, hresp, sck, cs_n;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [3:0] io_out, oe_n, f_io, io_in;
    logic [6:0] skip;
    logic [63:0] resp;
    logic [127:0] rx;
    int rises, driven, wide, n_errors, checks_done;
    assign io_in = (~oe_n & io_out) | (oe_n & f_io);
    spi_manual_xfer #(.SCK_HALF_CYCLES(HALF)) i_spi_manual_xfer (.i_mclk(i_mclk),
        .i_reset(i_reset), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
        .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_sck(sck),
        .o_cs_n(cs_n), .i_io(io_in), .o_io(io_out), .o_io_oe_n(oe_n));
    flash_model i_flash_model (.i_mclk(i_mclk), .i_clear(clr), .i_skip(skip),
        .i_resp(resp), .i_sck(sck), .i_cs_n(cs_n), .i_io(io_out), .i_io_oe_n(oe_n),
        .o_io(f_io), .o_rises(rises), .o_driven(driven), .o_wide(wide), .o_rx(rx));
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hwait(output logic [31:0] v);
        int n;
        logic r;
        n = 0;
        r = 1'b0;
        while (r !== 1'b1 && n < 64) begin
            @(negedge i_mclk);
            r = hreadyout;
            v = hrdata;
            @(posedge i_mclk);
            n++;
        end
        if (r !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: timeout", $time);
            test_done();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        @(posedge i_mclk);
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        hwait(v);
        htrans <= 2'h0;
        hwdata <= d;
        hwait(q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp32(q, e);
    endtask
    task automatic setup(input logic [31:0] pen, input logic [31:0] ddr,
                         input logic [31:0] dmy);
        bus(1'b1, `OFS_PHASE_ENABLE, pen);
        bus(1'b1, `OFS_DOUBLE_RATE, ddr);
        bus(1'b1, `OFS_DUMMY_SETUP, dmy);
    endtask
    task automatic run(input logic [2:0] ctl);
        int n;
        clr <= 1'b1;
        @(posedge i_mclk);
        clr <= 1'b0;
        bus(1'b1, `OFS_CONTROL, {29'h0, ctl});
        n = 0;
        q = 32'h1;
        while (q[0] !== 1'b0 && n < 1000) begin
            bus(1'b0, `OFS_CONTROL, 32'h0);
            n++;
        end
        cmp32({31'h0, q[0]}, 32'h0);
        if (q[0] !== 1'b0) test_done();
    endtask
    task automatic t_regs;
        logic [7:0] ofs [5] = '{`OFS_ADDRESS, `OFS_OPTION, `OFS_COMMAND, `OFS_WRITE0,
                                `OFS_WRITE1};
        logic [31:0] val [5] = '{32'h12345678, 32'h9d8e7f60, 32'h00a5003c, 32'hcafe0123,
                                 32'h4567beef};
        for (int a = 0; a <= 'h28; a += 4) rdc(8'(a), 32'h0);
        for (int i = 0; i < 5; i++) bus(1'b1, ofs[i], val[i]);
        for (int i = 0; i < 5; i++) rdc(ofs[i], val[i]);
        bus(1'b1, `OFS_READ0, 32'hffffffff);
        rdc(`OFS_READ0, 32'h0);
        bus(1'b1, 8'h40, 32'hffffffff);
        rdc(8'h40, 32'h0);
    endtask
    task automatic t_send;
        setup(32'h00005fcf, 32'h0, 32'h0);
        for (int w = 1; w >= 0; w--) begin
            run({w[0], 2'b01});
            cmp32(rises, 96);
            cmp32(driven, w ? 96 : 64);
            cmp32(rx[95:64], 32'ha53c1234);
            cmp32(rx[63:32], 32'h56789d8e);
            if (w == 1) cmp32(rx[31:0], 32'hcafe0123);
            cmp32(wide, 0);
        end
    endtask
    task automatic t_read;
        logic [2:0] cnts [4] = '{3'h7, 3'h0, 3'h5, 3'h2};
        logic den, rd;
        logic [1:0] wd;
        int n;
        for (int i = 0; i < 4; i++) begin
            den = (i != 2);
            rd = (i != 3);
            wd = i[0] ? 2'h0 : 2'h2;
            n = den ? int'(cnts[i]) + 1 : 0;
            skip <= 7'(8 + n);
            if (i == 3) resp <= 64'h0123456789abcdef;
            setup({16'h0, den, 15'h400f}, 32'h0, {14'h0, wd, 13'h0, cnts[i]});
            run({1'b0, rd, 1'b1});
            cmp32(rises, 40 + n);
            cmp32(wide, wd == 2'h2 ? n : 0);
            rdc(`OFS_READ0, 32'h96c35a0f);
            rdc(`OFS_READ1, 32'h0);
        end
    endtask
    task automatic t_ddr;
        logic [31:0] ddrs [4] = '{32'h0, 32'h1, 32'h10, 32'h100};
        bus(1'b1, `OFS_WRITE0, 32'haaaa0000);
        for (int i = 0; i < 4; i++) begin
            setup(32'h00004fc8, ddrs[i], 32'h0);
            run(3'b101);
            cmp32(rises, 16 + (i == 3 ? 16 : 32) + (i == 2 ? 8 : 16));
            cmp32({24'h0, rx[7:0]}, i == 1 ? 32'hff : 32'haa);
        end
    endtask
    initial begin
        i_reset = 1'b1;
        hsel = 1'b1;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        clr = 1'b0;
        skip = 7'h00;
        resp = 64'h96c35a0f0f1e2d3c;
        n_errors = 0;
        checks_done = 0;
        repeat (5) @(posedge i_mclk);
        i_reset <= 1'b0;
        t_regs();
        t_send();
        t_read();
        t_ddr();
        test_done();
    end
endmodule
